// ---- rtl/spms_pkg.sv ----
// Package with register map, field positions, reset values and counts for the serial port.
package spms_pkg;
	localparam logic [7:0] SPMS_DATA_ADDR = 8'h7F;
	localparam logic [7:0] SPMS_CTRL_ADDR = 8'hF8;
	localparam logic [7:0] SPMS_CTRL_RESET = 8'h05;
	localparam logic [7:0] SPMS_DATA_RESET = 8'h00;
	localparam int SPMS_BIT_DONE = 7;
	localparam int SPMS_BIT_WRITE_COLLISION_FLAG = 6;
	localparam int SPMS_BIT_PFE = 5;
	localparam int SPMS_BIT_MSTR = 4;
	localparam int SPMS_BIT_CPOL = 3;
	localparam int SPMS_BIT_CPHA = 2;
	localparam int SPMS_BIT_RATE_HI = 1;
	localparam int SPMS_BIT_RATE_LO = 0;
	localparam int SPMS_BYTE_BITS = 8;
	localparam logic [3:0] SPMS_LAST_EDGE = 4'hF;
	localparam logic [3:0] SPMS_LAST_BIT = 4'h7;
	localparam logic [3:0] SPMS_FULL_BYTE = 4'h8;
	localparam int SPMS_RATE_CNT_W = 3;
	localparam int SPMS_CLK_PERIOD_NS = 5;
	typedef enum logic [2:0] {
		SPMS_IDLE = 3'h1,
		SPMS_MST = 3'h2,
		SPMS_SLV = 3'h4
	} spms_state_t;
endpackage

// ---- rtl/spms_rate_gen.sv ----
// Master bit-rate tick generator: one pulse per serial clock half period.
`timescale 1ns/10ps
`default_nettype none
module spms_rate_gen import spms_pkg::*; #(
	parameter int CNT_W = SPMS_RATE_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [1:0] rate,
	// Half-period pulse
	output logic tick
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] half_last;

	if (CNT_W < SPMS_RATE_CNT_W) begin : g_chk
		$error("spms_rate_gen: CNT_W too narrow for divide by 16");
	end

	// Half period is 2**rate core cycles, so the full period is 2, 4, 8 or 16 cycles.
	always_comb begin
		half_last = CNT_W'((1 << rate) - 1);
		tick = run && (cnt == half_last);
		if (!run || tick) begin
			next_cnt = '0;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/spms_edge_det.sv ----
// Detects leading and trailing edges of the externally supplied serial clock.
`timescale 1ns/10ps
`default_nettype none
module spms_edge_det (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial clock and its idle level
	input wire logic sclk_in,
	input wire logic cpol,
	// Edge pulses
	output logic lead,
	output logic trail
);
	logic prev;
	logic next_prev;

	// The leading edge leaves the idle level, the trailing edge returns to it.
	always_comb begin
		next_prev = sclk_in;
		lead = (prev == cpol) && (sclk_in != cpol);
		trail = (prev != cpol) && (sclk_in == cpol);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/spms_top.sv ----
// Byte-wide master/slave serial port with control and data registers on the core register bus.
// Functional notes
// - Byte end sets done flag bit 7.
// - Done clears by zero write or data read.
// - Data write while busy sets collision bit 6.
// - Bit 5 hands shared pins to port.
// - Bit 4 selects master, drives serial clock.
// - Bit 3 sets serial clock idle level.
// - Bit 2 chooses leading or trailing drive edge.
// - Master rate core clock /2,/4,/8,/16.
// - Control resets to 0x05, data to 0x00.
// - Interrupt vector shared; software checks both.
// - Master data write starts eight-clock burst.
// - Master shifts MOSI out, samples MISO each period.
// - After eighth clock, received byte to data.
// - Master ignores slave-select input.
// - Slave write loads byte; bit per clock.
// - Slave completes at eighth clock or select rise.
// - Slave completion sets done flag, requests interrupt.
// - Eight bits per transfer, MSB first.
// - Drive on one edge, sample on other.
`timescale 1ns/10ps
`default_nettype none
module spms_top import spms_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Serial clock pin
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	// Master-out data pin
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	// Master-in data pin
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	// Slave select, active low
	input wire logic ss_n_in,
	// Core side status
	output logic xfer_irq_req,
	output logic pin_owner_spi
);
	spms_state_t state, next_state;
	logic xfer_done_flag, next_xfer_done_flag;
	logic write_collision_flag, next_write_collision_flag;
	logic port_function_enable, next_port_function_enable;
	logic master_select, next_master_select;
	logic cpol, next_cpol;
	logic cpha, next_cpha;
	logic rate_sel_hi, next_rate_sel_hi;
	logic rate_sel_lo, next_rate_sel_lo;
	logic [7:0] serial_data_reg, next_serial_data_reg;
	logic [7:0] tx_sh, next_tx_sh;
	logic [7:0] rx_sh, next_rx_sh;
	logic out_bit, next_out_bit;
	logic [3:0] edge_cnt, next_edge_cnt;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic next_sclk_out, next_sclk_oe, next_mosi_oe, next_miso_oe;
	logic [7:0] next_sfr_rdata;
	logic m_tick, s_lead, s_trail;
	logic wr_data, wr_ctrl, rd_data, rd_ctrl, busy;
	logic drive_edge, sample_edge, set_done;
	logic [7:0] ctrl_view;

	spms_rate_gen #(
		.CNT_W(SPMS_RATE_CNT_W)
	) u_rate (
		.clk(clk),
		.rst(rst),
		.run(state == SPMS_MST),
		.rate({rate_sel_hi, rate_sel_lo}),
		.tick(m_tick)
	);

	spms_edge_det u_edge (
		.clk(clk),
		.rst(rst),
		.sclk_in(sclk_in),
		.cpol(cpol),
		.lead(s_lead),
		.trail(s_trail)
	);

	always_comb begin
		wr_data = sfr_wr && (sfr_addr == SPMS_DATA_ADDR);
		wr_ctrl = sfr_wr && (sfr_addr == SPMS_CTRL_ADDR);
		rd_data = sfr_rd && (sfr_addr == SPMS_DATA_ADDR);
		rd_ctrl = sfr_rd && (sfr_addr == SPMS_CTRL_ADDR);
		ctrl_view = {xfer_done_flag, write_collision_flag, port_function_enable,
			master_select, cpol, cpha, rate_sel_hi, rate_sel_lo};
		// A slave counts as busy only once its first bit has been sampled.
		busy = (state == SPMS_MST) || ((state == SPMS_SLV) && (bit_cnt != 4'h0));
		next_state = state;
		next_serial_data_reg = serial_data_reg;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_out_bit = out_bit;
		next_edge_cnt = edge_cnt;
		next_bit_cnt = bit_cnt;
		next_sclk_out = cpol;
		drive_edge = 1'b0;
		sample_edge = 1'b0;
		set_done = 1'b0;
		next_port_function_enable = port_function_enable;
		next_master_select = master_select;
		next_cpol = cpol;
		next_cpha = cpha;
		next_rate_sel_hi = rate_sel_hi;
		next_rate_sel_lo = rate_sel_lo;
		if (wr_ctrl) begin
			next_port_function_enable = sfr_wdata[SPMS_BIT_PFE];
			next_master_select = sfr_wdata[SPMS_BIT_MSTR];
			next_cpol = sfr_wdata[SPMS_BIT_CPOL];
			next_cpha = sfr_wdata[SPMS_BIT_CPHA];
			next_rate_sel_hi = sfr_wdata[SPMS_BIT_RATE_HI];
			next_rate_sel_lo = sfr_wdata[SPMS_BIT_RATE_LO];
		end
		// A write during a byte is refused so the shifting byte stays intact.
		if (wr_data && !busy) begin
			next_serial_data_reg = sfr_wdata;
			if (cpha) begin
				next_tx_sh = sfr_wdata;
			end else begin
				next_tx_sh = {sfr_wdata[6:0], 1'b0};
				next_out_bit = sfr_wdata[7];
			end
		end
		case (state)
			SPMS_IDLE: begin
				if (port_function_enable && master_select && wr_data) begin
					next_state = SPMS_MST;
					next_edge_cnt = 4'h0;
				end else if (port_function_enable && !master_select && !ss_n_in) begin
					next_state = SPMS_SLV;
					next_bit_cnt = 4'h0;
				end
			end
			SPMS_MST: begin
				next_sclk_out = sclk_out;
				if (!port_function_enable || !master_select) begin
					next_state = SPMS_IDLE;
					next_sclk_out = cpol;
				end else if (m_tick) begin
					next_sclk_out = !sclk_out;
					// Even edge counts are leading edges.
					if (edge_cnt[0] == 1'b0) begin
						drive_edge = cpha;
						sample_edge = !cpha;
					end else begin
						drive_edge = !cpha;
						sample_edge = cpha;
					end
					next_edge_cnt = edge_cnt + 4'h1;
					if (sample_edge) begin
						next_rx_sh = {rx_sh[6:0], miso_in};
					end
					if (edge_cnt == SPMS_LAST_EDGE) begin
						next_serial_data_reg = next_rx_sh;
						set_done = 1'b1;
						next_state = SPMS_IDLE;
					end
				end
			end
			SPMS_SLV: begin
				if (!port_function_enable || master_select) begin
					next_state = SPMS_IDLE;
				end else if (ss_n_in) begin
					// Phase 0 ends a byte only when select returns high.
					if (!cpha && (bit_cnt == SPMS_FULL_BYTE)) begin
						next_serial_data_reg = rx_sh;
						set_done = 1'b1;
					end
					next_state = SPMS_IDLE;
				end else begin
					drive_edge = cpha ? s_lead : s_trail;
					sample_edge = cpha ? s_trail : s_lead;
					if (sample_edge) begin
						next_rx_sh = {rx_sh[6:0], mosi_in};
						next_bit_cnt = bit_cnt + 4'h1;
						if (cpha && (bit_cnt == SPMS_LAST_BIT)) begin
							next_serial_data_reg = next_rx_sh;
							set_done = 1'b1;
							next_bit_cnt = 4'h0;
						end
					end
				end
			end
			default: begin
				next_state = SPMS_IDLE;
			end
		endcase
		if (drive_edge) begin
			next_out_bit = tx_sh[7];
			next_tx_sh = {tx_sh[6:0], 1'b0};
		end
		// Hardware set wins over a software clear in the same cycle.
		next_xfer_done_flag = xfer_done_flag;
		if (wr_ctrl) begin
			next_xfer_done_flag = sfr_wdata[SPMS_BIT_DONE];
		end
		if (rd_data) begin
			next_xfer_done_flag = 1'b0;
		end
		if (set_done) begin
			next_xfer_done_flag = 1'b1;
		end
		next_write_collision_flag = write_collision_flag;
		if (wr_ctrl) begin
			next_write_collision_flag = sfr_wdata[SPMS_BIT_WRITE_COLLISION_FLAG];
		end
		if (wr_data && busy) begin
			next_write_collision_flag = 1'b1;
		end
		// Pins go back to the general port while the enable is clear.
		next_sclk_oe = port_function_enable && master_select;
		next_mosi_oe = port_function_enable && master_select;
		// The select input only matters to a slave.
		next_miso_oe = port_function_enable && !master_select && !ss_n_in;
		if (rd_data) begin
			next_sfr_rdata = serial_data_reg;
		end else if (rd_ctrl) begin
			next_sfr_rdata = ctrl_view;
		end else begin
			next_sfr_rdata = 8'h00;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= SPMS_IDLE;
			xfer_done_flag <= SPMS_CTRL_RESET[SPMS_BIT_DONE];
			write_collision_flag <= SPMS_CTRL_RESET[SPMS_BIT_WRITE_COLLISION_FLAG];
			port_function_enable <= SPMS_CTRL_RESET[SPMS_BIT_PFE];
			master_select <= SPMS_CTRL_RESET[SPMS_BIT_MSTR];
			cpol <= SPMS_CTRL_RESET[SPMS_BIT_CPOL];
			cpha <= SPMS_CTRL_RESET[SPMS_BIT_CPHA];
			rate_sel_hi <= SPMS_CTRL_RESET[SPMS_BIT_RATE_HI];
			rate_sel_lo <= SPMS_CTRL_RESET[SPMS_BIT_RATE_LO];
			serial_data_reg <= SPMS_DATA_RESET;
			tx_sh <= 8'h00;
			rx_sh <= 8'h00;
			out_bit <= 1'b0;
			edge_cnt <= 4'h0;
			bit_cnt <= 4'h0;
			sclk_out <= 1'b0;
			sclk_oe <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
			sfr_rdata <= 8'h00;
		end else begin
			state <= next_state;
			xfer_done_flag <= next_xfer_done_flag;
			write_collision_flag <= next_write_collision_flag;
			port_function_enable <= next_port_function_enable;
			master_select <= next_master_select;
			cpol <= next_cpol;
			cpha <= next_cpha;
			rate_sel_hi <= next_rate_sel_hi;
			rate_sel_lo <= next_rate_sel_lo;
			serial_data_reg <= next_serial_data_reg;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			out_bit <= next_out_bit;
			edge_cnt <= next_edge_cnt;
			bit_cnt <= next_bit_cnt;
			sclk_out <= next_sclk_out;
			sclk_oe <= next_sclk_oe;
			mosi_oe <= next_mosi_oe;
			miso_oe <= next_miso_oe;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// The request line is shared with another interface upstream.
	assign xfer_irq_req = xfer_done_flag;
	assign pin_owner_spi = port_function_enable;
	assign mosi_out = out_bit;
	assign miso_out = out_bit;
endmodule
`default_nettype wire

// ---- tb/spms_monitor.sv ----
// Port checker for the serial port in its master role, plus pin ownership, done flag and slave-output checks.
`timescale 1ns/10ps
`default_nettype none
module spms_monitor import spms_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	// Pins and status
	input wire logic sclk_out,
	input wire logic sclk_oe,
	input wire logic mosi_out,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic xfer_irq_req,
	input wire logic pin_owner_spi,
	input wire logic ss_n_in
);
	logic [7:0] cw;
	logic busy;
	logic sq;
	logic [4:0] tog;
	logic [8:0] bc;
	logic [4:0] gap;
	logic wd;
	logic edg;
	logic [8:0] span;
	assign wd = sfr_wr && sfr_addr == SPMS_DATA_ADDR;
	assign edg = sclk_out != sq;
	assign span = 9'h010 << cw[1:0];
	// Shadow of the control byte and burst counters, rebuilt from the bus, the serial clock output and the request line.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cw <= SPMS_CTRL_RESET;
			busy <= 1'b0;
			sq <= 1'b0;
			tog <= 5'h00;
			bc <= 9'h000;
			gap <= 5'h00;
		end else begin
			sq <= sclk_out;
			gap <= edg ? 5'h01 : gap + 5'h01;
			bc <= bc + 9'h001;
			if (edg && busy)
				tog <= tog + 5'h01;
			if (sfr_wr && sfr_addr == SPMS_CTRL_ADDR)
				cw <= sfr_wdata;
			if (wd && cw[5:4] == 2'h3 && !busy) begin
				busy <= 1'b1;
				tog <= 5'h00;
				bc <= 9'h000;
			end else if (xfer_irq_req) begin
				busy <= 1'b0;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_end;
		$rose(xfer_irq_req) && busy;
	endsequence
	property p_span;
		s_end |-> bc >= span && bc <= span + 9'h003;
	endproperty
	property p_tog;
		s_end |-> tog + 5'(edg) == 5'h10;
	endproperty
	property p_gap;
		busy && edg && tog != 5'h00 |-> gap == 5'(span >> 4);
	endproperty
	property p_drive;
		busy && $changed(mosi_out) && tog != 5'h00 |-> edg && ((sclk_out != cw[3]) == cw[2]);
	endproperty
	property p_idle;
		s_end |=> sclk_out == cw[3];
	endproperty
	property p_own;
		!pin_owner_spi && $past(!pin_owner_spi) |-> !sclk_oe && !mosi_oe && !miso_oe;
	endproperty
	property p_mst;
		sclk_oe |-> mosi_oe && !miso_oe;
	endproperty
	property p_rd;
		sfr_rd && sfr_addr == SPMS_DATA_ADDR && !busy |-> ##[1:2] !xfer_irq_req;
	endproperty
	property p_clr;
		sfr_wr && sfr_addr == SPMS_CTRL_ADDR && !sfr_wdata[7] && !busy |-> ##[1:2] !xfer_irq_req;
	endproperty
	property p_hold;
		xfer_irq_req && !sfr_rd && !sfr_wr |=> xfer_irq_req;
	endproperty
	property p_sel;
		miso_oe |-> $past(!ss_n_in) && !sclk_oe;
	endproperty
	a_sel: assert property (p_sel) else $error("slave output without select");
	a_span: assert property (p_span) else $error("burst length off");
	a_tog: assert property (p_tog) else $error("edge count off");
	a_gap: assert property (p_gap) else $error("clock spacing off");
	a_drive: assert property (p_drive) else $error("data moved on wrong edge");
	a_idle: assert property (p_idle) else $error("clock not idle");
	a_own: assert property (p_own) else $error("pins driven while off");
	a_mst: assert property (p_mst) else $error("master enables wrong");
	a_rd: assert property (p_rd) else $error("flag kept after read");
	a_clr: assert property (p_clr) else $error("flag kept after clear");
	a_hold: assert property (p_hold) else $error("flag dropped");
endmodule
`default_nettype wire

// ---- tb/spms_slave_model.sv ----
// Behavioural external slave facing the master port.
`timescale 1ns/10ps
`default_nettype none
module spms_slave_model (
	// Core clock, used to look back at the data line
	input wire logic clk,
	// Serial lines
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// Mode, outgoing byte, reload toggle and captured byte
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] tx,
	input wire logic load,
	output logic [7:0] rx
);
	logic mq;
	int e = 16;
	// The line as it stood before the edge, so a late change cannot pass.
	always @(negedge clk)
		mq = mosi;
	always @(load) begin
		e = 0;
		miso = cpha ? ~tx[7] : tx[7];
	end
	always @(sclk)
		if (e < 16) begin
			if ((sclk != cpol) ^ cpha)
				rx = {rx[6:0], mq};
			else
				miso = (e + 1) / 2 < 8 ? tx[7 - (e + 1) / 2] : ~miso;
			e++;
		end
endmodule
`default_nettype wire

// ---- tb/spms_top_test.sv ----
// Self-checking bench for the serial port as master and as slave.
`timescale 1ns/10ps
`default_nettype none
module spms_top_test import spms_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_in, miso_oe, xfer_irq_req, pin_owner_spi;
	logic ss_n_in = 1'b1;
	logic sclk_in = 1'b0;
	logic mosi_in = 1'b0;
	logic miso_out;
	logic [3:0] cfg = 4'h0;
	logic [7:0] stx = 8'h00;
	logic sload = 1'b0;
	logic [7:0] rx;
	int errors = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	spms_top spms_top_inst (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.sclk_in, .sclk_out, .sclk_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in,
		.miso_out, .miso_oe, .ss_n_in, .xfer_irq_req, .pin_owner_spi);
	spms_slave_model spms_slave_model_inst (.clk, .sclk(sclk_out), .mosi(mosi_out),
		.miso(miso_in), .cpol(cfg[3]), .cpha(cfg[2]), .tx(stx), .load(sload), .rx);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(negedge clk);
		d = sfr_rdata;
	endtask
	// External master for the slave role: half period of four core clocks, mode from cfg.
	task automatic sx(input logic [7:0] mo, output logic [7:0] mi);
		ss_n_in <= 1'b0;
		mosi_in <= mo[7];
		repeat (4) @(posedge clk);
		for (int b = 7; b >= 0; b--) begin
			@(negedge clk);
			if (!cfg[2]) begin
				mi[b] = miso_out;
			end
			@(posedge clk);
			sclk_in <= !cfg[3];
			if (cfg[2]) begin
				mosi_in <= mo[b];
			end
			repeat (3) @(posedge clk);
			@(negedge clk);
			if (cfg[2]) begin
				mi[b] = miso_out;
			end
			@(posedge clk);
			sclk_in <= cfg[3];
			if (!cfg[2] && b > 0) begin
				mosi_in <= mo[b - 1];
			end
			repeat (3) @(posedge clk);
		end
		ss_n_in <= 1'b1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		results;
	end
	initial begin
		logic [7:0] d;
		logic [7:0] c;
		int k;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(SPMS_CTRL_ADDR, d);
		chk(d, SPMS_CTRL_RESET);
		rd(SPMS_DATA_ADDR, d);
		chk(d, SPMS_DATA_RESET);
		rd(8'h10, d);
		chk(d, 8'h00);
		// Every polarity, phase and rate; one run writes again mid-byte.
		for (int i = 0; i < 16; i++) begin
			c = 8'h30 | 8'(i) | (i == 5 ? 8'h40 : 8'h00);
			wr(SPMS_CTRL_ADDR, 8'h30 | 8'(i));
			cfg <= 4'(i);
			stx <= 8'h3C ^ 8'(i);
			ss_n_in <= i[0];
			repeat (2) @(posedge clk);
			sload <= ~sload;
			wr(SPMS_DATA_ADDR, 8'hA5 + 8'(i));
			if (i == 5)
				wr(SPMS_DATA_ADDR, 8'h00);
			k = 0;
			while (xfer_irq_req !== 1'b1 && k < 400) begin
				@(posedge clk);
				k++;
			end
			chk({7'h00, xfer_irq_req}, 8'h01);
			rd(SPMS_CTRL_ADDR, d);
			chk(d, c | 8'h80);
			chk({7'h00, sclk_out}, {7'h00, cfg[3]});
			chk({4'h0, sclk_oe, mosi_oe, miso_oe, pin_owner_spi}, 8'h0D);
			rd(SPMS_DATA_ADDR, d);
			chk(d, 8'h3C ^ 8'(i));
			chk(rx, 8'hA5 + 8'(i));
			rd(SPMS_CTRL_ADDR, d);
			chk(d, c);
		end
		// Master role with the port switched off must leave the pins alone.
		wr(SPMS_CTRL_ADDR, 8'h10);
		wr(SPMS_DATA_ADDR, 8'h11);
		repeat (40) @(posedge clk);
		chk({3'h0, sclk_oe, mosi_oe, miso_oe, pin_owner_spi, xfer_irq_req}, 8'h00);
		// Slave role in every polarity and phase, clocked from outside.
		for (int m = 0; m < 4; m++) begin
			wr(SPMS_CTRL_ADDR, 8'h20 | 8'(m << 2));
			cfg <= 4'(m << 2);
			sclk_in <= m[1];
			wr(SPMS_DATA_ADDR, 8'h5A ^ 8'(m));
			sx(8'hC3 + 8'(m), d);
			repeat (3) @(posedge clk);
			chk(d, 8'h5A ^ 8'(m));
			chk({7'h00, xfer_irq_req}, 8'h01);
			chk({7'h00, miso_oe}, 8'h00);
			rd(SPMS_DATA_ADDR, d);
			chk(d, 8'hC3 + 8'(m));
		end
		results;
	end
endmodule
bind spms_top spms_monitor spms_monitor_inst (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
	.sfr_wdata, .sclk_out, .sclk_oe, .mosi_out, .mosi_oe, .miso_oe, .xfer_irq_req,
	.pin_owner_spi, .ss_n_in);
`default_nettype wire
